// ---- hdl/gpc_change_det.sv ----
// Purpose: Pin change detection for one group of eight pins
// Assumes: Pins already synchronised
// Notes:   Request is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module gpc_change_det (
    input  wire logic   clock_i,
    input  wire logic   arst_n_i,
    gpc_change_if.det   chg
);
    logic [7:0] prev_r;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= 8'h00;
        end else begin
            prev_r <= chg.pins;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chg.req <= 1'b0;
        end else begin
            chg.req <= chg.group_en & (|((prev_r ^ chg.pins) & chg.mask));
        end
    end
endmodule // gpc_change_det
`default_nettype wire

// ---- hdl/gpc_change_if.sv ----
// Purpose: Carries one group's pins and mask to a change detector
// Assumes: Single clock
// Notes:   Detector drives the request back
`timescale 1ns/100ps
`default_nettype none
interface gpc_change_if;
    logic [7:0] pins;
    logic [7:0] mask;
    logic       group_en;
    logic       req;
    modport ctl (output pins, output mask, output group_en, input req);
    modport det (input pins, input mask, input group_en, output req);
endinterface : gpc_change_if
`default_nettype wire

// ---- hdl/gpc_pin_sync.sv ----
// Purpose: Input synchroniser, falling-edge stage then rising-edge stage
// Assumes: Pins asynchronous to the clock
// Notes:   Negedge flop stands in for the transparent-high latch
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         clock_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] latch_r;

    // Catches the level present while clock was high
    always_ff @(negedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latch_r <= '0;
        end else begin
            latch_r <= pin_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_o <= '0;
        end else begin
            sync_o <= latch_r;
        end
    end
endmodule // gpc_pin_sync
`default_nettype wire

// ---- hdl/gpc_pkg.sv ----
// Purpose: Constants for the port and pin change mask block
// Assumes: Byte-wide I/O bus, one clock
// Notes:   Port register offsets are not fixed and are parameters here
package gpc_pkg;
    localparam int unsigned WIDTH = 8;
    localparam logic [7:0] MASK0_ADDR = 8'h6B;
    localparam logic [7:0] MASK1_ADDR = 8'h6C;
    localparam logic [7:0] MASK2_ADDR = 8'h6D;
    localparam logic [7:0] MASK3_ADDR = 8'h6E;
    localparam logic [7:0] PIN_ADDR = 8'h20;
    localparam logic [7:0] DIR_ADDR = 8'h21;
    localparam logic [7:0] OUT_ADDR = 8'h22;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] MASK3_VALID = 8'h7F;
endpackage : gpc_pkg

// ---- hdl/gpc_port.sv ----
// Purpose: One 8-bit I/O port with pin change masks and group flags
// Assumes: Core I/O bus with address, write strobe, read strobe
// Notes:
// Notes on behaviour
// - Direction one drives, zero is input
// - Input pull-up when output bit set, enabled
// - Global pull-up disable kills every pull-up
// - Output drives the output-value bit
// - Reset tri-states pins without a clock
// - Writing one to pin input toggles output
// - Three locations: output, direction, pin input
// - Single-bit writes leave other pins alone
// - Alternate function does not block others
// - Pin input via latch, then rising flop
// - External change seen after half to 1.5
// - Written value reads back one clock later
// - Mask bit and group enable gate detection
// - Four mask groups, upper one seven bits
// - Group change flag, cleared by one
`timescale 1ns/100ps
`default_nettype none
module gpc_port #(
    parameter bit         LARGE_VARIANT = 1'b1,
    parameter logic [7:0] PIN_ADDR      = gpc_pkg::PIN_ADDR,
    parameter logic [7:0] DIR_ADDR      = gpc_pkg::DIR_ADDR,
    parameter logic [7:0] OUT_ADDR      = gpc_pkg::OUT_ADDR
) (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        global_pullup_disable_i,
    input  wire logic [3:0]  change_group_enable_i,
    input  wire logic [3:0]  change_flag_clear_i,
    output logic      [3:0]  change_flag_o,
    input  wire logic [7:0]  pin_in_i,
    input  wire logic [31:0] group_pins_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pin_pullup_o
);
    logic [7:0]  port_output_value_r;
    logic [7:0]  port_output_value_nxt;
    logic [7:0]  port_direction_r;
    logic [7:0]  port_direction_nxt;
    logic [7:0]  port_pin_input;
    logic [7:0]  pin_change_mask_group0_r;
    logic [7:0]  pin_change_mask_group1_r;
    logic [7:0]  pin_change_mask_group2_r;
    logic [7:0]  pin_change_mask_group3_r;
    logic [7:0]  drive_nxt;
    logic [7:0]  pull_nxt;
    logic [7:0]  oe_r;
    logic [7:0]  out_r;
    logic [7:0]  pull_r;
    logic [7:0]  rdata_nxt;
    logic [31:0] group_sync;
    logic [3:0]  group_live;
    logic [3:0]  req;
    logic [3:0]  flag_nxt;
    logic [3:0]  flag_r;
    logic        sel_pin;
    logic        sel_dir;
    logic        sel_out;
    logic        sel_mask0;
    logic        sel_mask1;
    logic        sel_mask2;
    logic        sel_mask3;
    logic        write_pin;
    logic        write_dir;
    logic        write_out;
    logic        write_mask0;
    logic        write_mask1;
    logic        write_mask2;
    logic        write_mask3;

    // Pin input path
    gpc_pin_sync #(.W(8)) u_port_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .pin_i    (pin_in_i),
        .sync_o   (port_pin_input)
    );

    // Change sources for all four groups share one synchroniser bank
    gpc_pin_sync #(.W(32)) u_group_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .pin_i    (group_pins_i),
        .sync_o   (group_sync)
    );

    // Address decode, shared by the write and read paths
    assign sel_pin   = addr_i == PIN_ADDR;
    assign sel_dir   = addr_i == DIR_ADDR;
    assign sel_out   = addr_i == OUT_ADDR;
    assign sel_mask0 = addr_i == gpc_pkg::MASK0_ADDR;
    assign sel_mask1 = addr_i == gpc_pkg::MASK1_ADDR;
    // Upper groups decode to nothing in the small variant
    assign sel_mask2 = LARGE_VARIANT && addr_i == gpc_pkg::MASK2_ADDR;
    assign sel_mask3 = LARGE_VARIANT && addr_i == gpc_pkg::MASK3_ADDR;

    // Write strobes, one per location
    assign write_pin   = wr_i && sel_pin;
    assign write_dir   = wr_i && sel_dir;
    assign write_out   = wr_i && sel_out;
    assign write_mask0 = wr_i && sel_mask0;
    assign write_mask1 = wr_i && sel_mask1;
    assign write_mask2 = wr_i && sel_mask2;
    assign write_mask3 = wr_i && sel_mask3;

    // Output value: writes and toggles both go through the full byte,
    // so a bit-level write from the core touches only its own pin
    always_comb begin
        port_output_value_nxt = port_output_value_r;
        if (write_out) begin
            port_output_value_nxt = wdata_i;
        end else if (write_pin) begin
            // Toggle ignores direction; zero bits keep their value
            port_output_value_nxt = port_output_value_r ^ wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_output_value_r <= gpc_pkg::OUT_RST;
        end else begin
            port_output_value_r <= port_output_value_nxt;
        end
    end

    always_comb begin
        port_direction_nxt = port_direction_r;
        if (write_dir) begin
            port_direction_nxt = wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_direction_r <= gpc_pkg::DIR_RST;
        end else begin
            port_direction_r <= port_direction_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_change_mask_group0_r <= gpc_pkg::MASK_RST;
        end else if (write_mask0) begin
            pin_change_mask_group0_r <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_change_mask_group1_r <= gpc_pkg::MASK_RST;
        end else if (write_mask1) begin
            pin_change_mask_group1_r <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_change_mask_group2_r <= gpc_pkg::MASK_RST;
        end else if (write_mask2) begin
            pin_change_mask_group2_r <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_change_mask_group3_r <= gpc_pkg::MASK_RST;
        end else if (write_mask3) begin
            // Bit 7 has no pin behind it
            pin_change_mask_group3_r <= wdata_i & gpc_pkg::MASK3_VALID;
        end
    end

    // Pad controls follow the next register value, so a written level
    // is on the pin at the write edge and reads back a clock later
    assign drive_nxt = port_output_value_nxt & port_direction_nxt;
    assign pull_nxt  = ~port_direction_nxt & port_output_value_nxt
                       & {8{~global_pullup_disable_i}};

    // Async reset tri-states the pins with no clock running
    // Alternate functions are outside; each pin decodes alone
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_r <= 8'h00;
        end else begin
            oe_r <= port_direction_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_r <= 8'h00;
        end else begin
            out_r <= drive_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pull_r <= 8'h00;
        end else begin
            pull_r <= pull_nxt;
        end
    end

    assign pin_oe_o     = oe_r;
    assign pin_out_o    = out_r;
    assign pin_pullup_o = pull_r;

    // Read mux; unmapped locations read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (sel_pin) begin
            rdata_nxt = port_pin_input;
        end
        if (sel_dir) begin
            rdata_nxt = port_direction_r;
        end
        if (sel_out) begin
            rdata_nxt = port_output_value_r;
        end
        if (sel_mask0) begin
            rdata_nxt = pin_change_mask_group0_r;
        end
        if (sel_mask1) begin
            rdata_nxt = pin_change_mask_group1_r;
        end
        if (sel_mask2) begin
            rdata_nxt = pin_change_mask_group2_r;
        end
        if (sel_mask3) begin
            rdata_nxt = pin_change_mask_group3_r;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end
    end

    // Groups 2 and 3 exist only in the large variant
    always_comb begin
        group_live = change_group_enable_i;
        if (!LARGE_VARIANT) begin
            group_live[3:2] = 2'b00;
        end
    end

    // One detector per group
    gpc_change_if chg_if [4] ();
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_grp
            logic [7:0] mask_w;
            if (g == 0) begin : g_m0
                assign mask_w = pin_change_mask_group0_r;
            end else if (g == 1) begin : g_m1
                assign mask_w = pin_change_mask_group1_r;
            end else if (g == 2) begin : g_m2
                assign mask_w = pin_change_mask_group2_r;
            end else begin : g_m3
                assign mask_w = pin_change_mask_group3_r;
            end
            assign chg_if[g].pins     = group_sync[g*8 +: 8];
            assign chg_if[g].mask     = mask_w;
            assign chg_if[g].group_en = group_live[g];
            assign req[g]             = chg_if[g].req;
            gpc_change_det u_det (
                .clock_i  (clock_i),
                .arst_n_i (arst_n_i),
                .chg      (chg_if[g])
            );
        end
    endgenerate

    // Sticky flags; a new request wins over a same-cycle clear
    always_comb begin
        flag_nxt = flag_r & ~change_flag_clear_i;
        flag_nxt = flag_nxt | req;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign change_flag_o = flag_r;
endmodule // gpc_port
`default_nettype wire

// ---- verification/gpc_board.sv ----
// Purpose: Board circuitry on the port pins
// Assumes: Bench picks which pins the board drives
// Notes:   Floating pins wobble every cycle, never hold a value
`timescale 1ns/100ps
`default_nettype none
module gpc_board (
    input  wire logic       clock_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pin_o
);
    logic [7:0] wobble_r = 8'h00;
    always_ff @(posedge clock_i) wobble_r <= ~wobble_r;
    // Pad driver wins over the board; pull-up only where nobody drives
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pu_i | wobble_r));
endmodule // gpc_board
`default_nettype wire

// ---- verification/gpc_port_asserts.sv ----
// Purpose: Port-level checks for the I/O port
// Assumes: Sees top-level ports only
// Notes:   Group checks sample groups 0 and 1
`timescale 1ns/100ps
`default_nettype none
module gpc_port_asserts (
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       global_pullup_disable_i,
    input  wire logic [3:0] change_group_enable_i,
    input  wire logic [3:0] change_flag_clear_i,
    input  wire logic [3:0] change_flag_o,
    input  wire logic [7:0] pin_out_o,
    input  wire logic [7:0] pin_oe_o,
    input  wire logic [7:0] pin_pullup_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    a_reset_tri_state: assert property (disable iff (1'b0)
        !arst_n_i |-> pin_oe_o == 8'h00) else $error("pins driven in reset");
    a_pud_kills_pullup: assert property (
        $past(global_pullup_disable_i) |-> pin_pullup_o == 8'h00)
        else $error("pull-up on while disabled");
    a_pullup_input_only: assert property (
        (pin_pullup_o & pin_oe_o) == 8'h00) else $error("pull-up on output");
    a_out_input_zero: assert property (
        (pin_out_o & ~pin_oe_o) == 8'h00) else $error("value on input pin");
    a_flag_sticky: assert property (
        change_flag_o[0] && !change_flag_clear_i[0] |=> change_flag_o[0])
        else $error("flag lost without clear");
    a_flag_needs_en: assert property (
        !change_group_enable_i[0] [*3] |=> !$rose(change_flag_o[0]))
        else $error("flag set while group off");
    a_flag_cleared: assert property (
        (change_flag_clear_i[1] && !change_group_enable_i[1]) [*3]
        |=> !change_flag_o[1]) else $error("flag not cleared");
    a_rdata_holds: assert property (
        !rd_i |=> $stable(rdata_o)) else $error("read data moved");
    a_mask3_top_zero: assert property (
        rd_i && addr_i == gpc_pkg::MASK3_ADDR |=> !rdata_o[7])
        else $error("mask3 bit 7 set");
    a_unmapped_zero: assert property (
        rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // gpc_port_asserts
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the I/O port
// Assumes: Board model closes the pad loop
// Notes:   Only pins with a known level are compared on read
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clock_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        global_pullup_disable = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  ext_en = 8'h00;
    logic [7:0]  ext = 8'h00;
    logic [3:0]  gen = 4'h0;
    logic [3:0]  fclr = 4'h0;
    logic [31:0] grp = 32'h0;
    logic [7:0]  rdata_o, pin, pout, poe, ppu, m_out, m_dir, e, k, rdata_s;
    logic [3:0]  flag, flag_s;
    logic [31:0] v;
    int          failures = 0;
    int          total_checks = 0;
    int          seed = 89511;
    always #2 clock_i = ~clock_i;
    gpc_port dut_u (.clock_i, .arst_n_i, .addr_i, .wr_i, .rd_i, .wdata_i,
        .rdata_o, .global_pullup_disable_i(global_pullup_disable), .change_group_enable_i(gen),
        .change_flag_clear_i(fclr), .change_flag_o(flag), .pin_in_i(pin),
        .group_pins_i(grp), .pin_out_o(pout), .pin_oe_o(poe),
        .pin_pullup_o(ppu));
    gpc_board board_u (.clock_i, .oe_i(poe), .out_i(pout), .pu_i(ppu),
        .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin));
    gpc_port #(.LARGE_VARIANT(1'b0)) small_u (.clock_i, .arst_n_i, .addr_i,
        .wr_i, .rd_i, .wdata_i, .rdata_o(rdata_s),
        .global_pullup_disable_i(global_pullup_disable), .change_group_enable_i(gen),
        .change_flag_clear_i(fclr), .change_flag_o(flag_s), .pin_in_i(pin),
        .group_pins_i(grp), .pin_out_o(), .pin_oe_o(), .pin_pullup_o());
    task automatic chk(string nm, logic [7:0] x, logic [7:0] g);
        total_checks++;
        if (x !== g) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        step(1);
        wr_i = w;
        rd_i = !w;
        addr_i = a;
        wdata_i = d;
        step(1);
        wr_i = 1'b0;
        rd_i = 1'b0;
    endtask
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        finish_test();
    end
    initial begin
        step(4);
        arst_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 8'(gpc_pkg::MASK0_ADDR + i), 8'h00);
            chk("mask reset", gpc_pkg::MASK_RST, rdata_o);
            v = $random(seed);
            acc(1'b1, 8'(gpc_pkg::MASK0_ADDR + i), v[7:0]);
            acc(1'b0, 8'(gpc_pkg::MASK0_ADDR + i), 8'h00);
            chk("mask", (i == 3) ? v[7:0] & 8'h7F : v[7:0], rdata_o);
            chk("small mask", (i >= 2) ? 8'h00 : v[7:0], rdata_s);
        end
        acc(1'b0, 8'h00, 8'h00);
        chk("unmapped", 8'h00, rdata_o);
        m_out = gpc_pkg::OUT_RST;
        m_dir = gpc_pkg::DIR_RST;
        repeat (20) begin
            v = $random(seed);
            global_pullup_disable = v[24];
            ext_en = v[15:8];
            ext = v[23:16];
            acc(1'b1, gpc_pkg::OUT_ADDR, v[7:0]);
            m_out = v[7:0];
            v = $random(seed);
            acc(1'b1, gpc_pkg::DIR_ADDR, v[7:0]);
            m_dir = v[7:0];
            v = $random(seed);
            acc(1'b1, gpc_pkg::PIN_ADDR, v[7:0]);
            m_out = m_out ^ v[7:0];
            step(2);
            chk("drive enable", m_dir, poe);
            chk("drive value", m_out & m_dir, pout);
            e = global_pullup_disable ? 8'h00 : m_out & ~m_dir;
            chk("pull-up", e, ppu);
            k = m_dir | ext_en | e;
            e = (m_out & m_dir) | (~m_dir & ext_en & ext) | (~ext_en & e);
            acc(1'b0, gpc_pkg::PIN_ADDR, 8'h00);
            chk("pin input", e & k, rdata_o & k);
            acc(1'b0, gpc_pkg::OUT_ADDR, 8'h00);
            chk("output reg", m_out, rdata_o);
        end
        global_pullup_disable = 1'b0;
        acc(1'b1, gpc_pkg::DIR_ADDR, 8'h00);
        acc(1'b1, gpc_pkg::OUT_ADDR, 8'h00);
        acc(1'b1, gpc_pkg::OUT_ADDR, 8'hFF);
        chk("step pull-up", 8'hFF, ppu);
        acc(1'b1, gpc_pkg::DIR_ADDR, 8'hFF);
        acc(1'b0, gpc_pkg::PIN_ADDR, 8'h00);
        chk("readback high", 8'hFF, rdata_o);
        acc(1'b1, gpc_pkg::DIR_ADDR, 8'h00);
        acc(1'b1, gpc_pkg::OUT_ADDR, 8'h00);
        acc(1'b1, gpc_pkg::DIR_ADDR, 8'hFF);
        acc(1'b0, gpc_pkg::PIN_ADDR, 8'h00);
        chk("readback low", 8'h00, rdata_o);
        for (int g = 0; g < 4; g++) begin
            acc(1'b1, 8'(gpc_pkg::MASK0_ADDR + g), 8'h01);
            grp[8 * g] = ~grp[8 * g];
            step(6);
            chk("flag disabled", 8'h00, {4'h0, flag});
            gen = 4'(1 << g);
            grp[8 * g + 1] = ~grp[8 * g + 1];
            step(6);
            chk("flag masked", 8'h00, {4'h0, flag});
            grp[8 * g] = ~grp[8 * g];
            step(6);
            chk("flag set", 8'(1 << g), {4'h0, flag});
            chk("small flag", 8'h00, {4'h0, flag_s & 4'hC});
            gen = 4'h0;
            fclr = 4'(1 << g);
            step(4);
            fclr = 4'h0;
            chk("flag clear", 8'h00, {4'h0, flag});
        end
        arst_n_i = 1'b0;
        step(1);
        chk("reset drive", 8'h00, poe);
        chk("reset pull-up", 8'h00, ppu);
        arst_n_i = 1'b1;
        acc(1'b0, gpc_pkg::DIR_ADDR, 8'h00);
        chk("dir reset", gpc_pkg::DIR_RST, rdata_o);
        finish_test();
    end
endmodule // testbench
bind gpc_port gpc_port_asserts chk_u (.clock_i, .arst_n_i, .addr_i, .rd_i,
    .rdata_o, .global_pullup_disable_i, .change_group_enable_i,
    .change_flag_clear_i, .change_flag_o, .pin_out_o, .pin_oe_o,
    .pin_pullup_o);
`default_nettype wire
